/* File: design/pms_pkg.sv */
// Constants and types for the operating-mode and clock sequencer
package pms_pkg;

   // ==================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_SYSCLK_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FAST_OSC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_WAKE_EN = 8'h0c;
   localparam logic [7:0] ADDR_INT_EN = 8'h10;

   // ==================================================
   // Field positions and reset values
   localparam int SEL_LSB = 5;
   localparam int SEL_W = 3;
   localparam int HS_IDLE_BIT = 1;
   localparam int LS_IDLE_BIT = 0;
   localparam int HS_EN_BIT = 0;
   localparam int HS_STABLE_BIT = 1;
   localparam int PDF_BIT = 0;
   localparam int TO_BIT = 1;
   localparam int SLOW_ACT_BIT = 2;
   localparam int LS_STABLE_BIT = 3;
   localparam int MODE_LSB = 4;
   localparam logic [2:0] SEL_SLOW = 3'h7;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic HS_EN_RESET = 1'b1;

   // ==================================================
   // Oscillator start-up times
   localparam int CLK_PERIOD_NS = 100;
   localparam int HS_START_NS = 1600;
   localparam int LS_START_NS = 3200;
   localparam int HS_START_CYC =
      (HS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LS_START_CYC =
      (LS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // ==================================================
   // Types
   typedef enum logic [2:0] {
      MODE_RUN = 3'h0,
      MODE_SLEEP = 3'h1,
      MODE_IDLE_SLOW = 3'h2,
      MODE_IDLE_BOTH = 3'h3,
      MODE_IDLE_FAST = 3'h4
   } pms_mode_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_HALTED = 2'h1,
      ST_WAKE = 2'h2
   } pms_state_t;

   typedef struct packed {
      logic halt;
      logic clr_wdt;
      logic wdt_enable;
      logic wdt_overflow;
      logic stack_full;
   } pms_cpu_req_t;

   typedef struct packed {
      logic stall;
      logic wake;
      logic int_response;
      logic pc_sp_reset;
      logic wdt_clear;
      logic wdt_run;
   } pms_cpu_rsp_t;

endpackage

/* File: design/pms_sequencer.sv */
// Operating-mode and clock sequencer with APB register access
//
// Functional notes
// - Enable write clears stable flag until settled
// - Fast control bits 7..2 read zero
// - Fast oscillator enable bit, resets to one
// - Select 111 moves system clock to slow
// - Slow switch waits for slow oscillator stable
// - Select 000..110 gives fast divided clock
// - Stable flag reports fast restart to software
// - Halt with both idle bits zero: sleep
// - Halt, slow idle only: fast stops
// - Halt, both idle bits: both clocks run
// - Halt, fast idle only: slow runs only with watchdog
// - Low-power entry keeps the control registers unchanged
// - Halt sets power-down, clears timeout flag
// - Halt clears watchdog; runs only if enabled
// - Wake on port A edge, interrupt, overflow
// - Power-down flag cleared by reset, clear-watchdog
// - Overflow wake sets timeout, resets PC/SP
// - Per-pin port A wake enable, resume after
// - Disabled or stack-full interrupt: resume after
// - Enabled interrupt with stack room: interrupt
// - Interrupt pending before halt cannot wake
// - Wake waits for system oscillator stable
// - Clock control: select 7..5, idle bits 1..0
// - Sleep keeps slow oscillator only with watchdog
//
// Local design decisions: the address map and the APB slave port.
module pms_sequencer #(
   parameter int PORTA_W = 8,
   parameter int INT_W = 4,
   parameter int HS_CYC = pms_pkg::HS_START_CYC,
   parameter int LS_CYC = pms_pkg::LS_START_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU core
   input wire pms_pkg::pms_cpu_req_t cpu_req,
   output pms_pkg::pms_cpu_rsp_t cpu_rsp,
   // Wake sources
   input wire logic [PORTA_W-1:0] porta_in,
   input wire logic [INT_W-1:0] int_req,
   // Clock controls
   output logic fast_osc_on,
   output logic slow_osc_on,
   output logic sysclk_is_slow,
   output logic [2:0] sysclk_div_sel,
   output logic sysclk_run,
   output pms_pkg::pms_mode_t mode
);

   // ==================================================
   // Registers
   logic [2:0] sel_ff;
   logic hs_idle_ff, ls_idle_ff, hs_en_ff, pdf_ff, to_ff, slow_act_ff;
   logic [PORTA_W-1:0] wake_en_ff, porta_prev_ff;
   logic [INT_W-1:0] int_en_ff, int_snap_ff;
   logic [pms_pkg::CNT_W-1:0] hs_cnt_ff, ls_cnt_ff;
   pms_pkg::pms_state_t state_ff;
   pms_pkg::pms_mode_t mode_ff;
   logic wake_wdt_ff, wake_int_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, fast_on_ff, slow_on_ff;
   pms_pkg::pms_cpu_rsp_t rsp_ff;
   logic setup, wr_en, hs_stable, ls_stable, porta_fall, int_new;
   logic wake_any, halted, wake_done, nxt_fast_on, nxt_slow_on, nxt_err;
   logic [31:0] nxt_prdata;
   pms_pkg::pms_mode_t nxt_mode;
   localparam logic [pms_pkg::CNT_W-1:0] HS_MAX = pms_pkg::CNT_W'(HS_CYC);
   localparam logic [pms_pkg::CNT_W-1:0] LS_MAX = pms_pkg::CNT_W'(LS_CYC);

   // ==================================================
   // APB access
   assign setup = psel && !penable && !pready_ff;
   assign wr_en = psel && penable && pready_ff && pwrite;
   always_comb begin
      nxt_prdata = '0;
      nxt_err = 1'b0;
      case (paddr)
         pms_pkg::ADDR_SYSCLK_CTRL: begin
            nxt_prdata[pms_pkg::SEL_LSB +: pms_pkg::SEL_W] = sel_ff;
            nxt_prdata[pms_pkg::HS_IDLE_BIT] = hs_idle_ff;
            nxt_prdata[pms_pkg::LS_IDLE_BIT] = ls_idle_ff;
         end
         pms_pkg::ADDR_FAST_OSC: begin
            nxt_prdata[pms_pkg::HS_EN_BIT] = hs_en_ff;
            nxt_prdata[pms_pkg::HS_STABLE_BIT] = hs_stable;
         end
         pms_pkg::ADDR_STATUS: begin
            nxt_prdata[pms_pkg::PDF_BIT] = pdf_ff;
            nxt_prdata[pms_pkg::TO_BIT] = to_ff;
            nxt_prdata[pms_pkg::SLOW_ACT_BIT] = slow_act_ff;
            nxt_prdata[pms_pkg::LS_STABLE_BIT] = ls_stable;
            nxt_prdata[pms_pkg::MODE_LSB +: 3] = mode_ff;
         end
         pms_pkg::ADDR_WAKE_EN: nxt_prdata[PORTA_W-1:0] = wake_en_ff;
         pms_pkg::ADDR_INT_EN: nxt_prdata[INT_W-1:0] = int_en_ff;
         default: nxt_err = 1'b1;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup && nxt_err;
         if (setup) begin
            prdata_ff <= pwrite ? '0 : nxt_prdata;
         end
      end
   end

   // ==================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_ff <= pms_pkg::SEL_RESET;
         hs_idle_ff <= 1'b0;
         ls_idle_ff <= 1'b0;
         hs_en_ff <= pms_pkg::HS_EN_RESET;
         wake_en_ff <= '0;
         int_en_ff <= '0;
      end else if (wr_en) begin
         case (paddr)
            pms_pkg::ADDR_SYSCLK_CTRL: begin
               sel_ff <= pwdata[pms_pkg::SEL_LSB +: pms_pkg::SEL_W];
               hs_idle_ff <= pwdata[pms_pkg::HS_IDLE_BIT];
               ls_idle_ff <= pwdata[pms_pkg::LS_IDLE_BIT];
            end
            pms_pkg::ADDR_FAST_OSC: begin
               hs_en_ff <= pwdata[pms_pkg::HS_EN_BIT];
            end
            pms_pkg::ADDR_WAKE_EN: begin
               wake_en_ff <= pwdata[PORTA_W-1:0];
            end
            pms_pkg::ADDR_INT_EN: int_en_ff <= pwdata[INT_W-1:0];
            default: ;
         endcase
      end
   end

   // ==================================================
   // Oscillator enables and start-up timers
   assign halted = (state_ff == pms_pkg::ST_HALTED);
   assign wake_done = (state_ff == pms_pkg::ST_WAKE) &&
                      (slow_act_ff ? ls_stable : hs_stable);
   always_comb begin
      nxt_fast_on = 1'b1;
      nxt_slow_on = 1'b1;
      if (halted) begin
         case (mode_ff)
            pms_pkg::MODE_SLEEP: begin
               nxt_fast_on = 1'b0;
               nxt_slow_on = cpu_req.wdt_enable;
            end
            pms_pkg::MODE_IDLE_SLOW: begin
               nxt_fast_on = 1'b0;
               nxt_slow_on = 1'b1;
            end
            pms_pkg::MODE_IDLE_FAST: begin
               nxt_fast_on = 1'b1;
               nxt_slow_on = cpu_req.wdt_enable;
            end
            default: begin
               nxt_fast_on = 1'b1;
               nxt_slow_on = 1'b1;
            end
         endcase
      end else if (slow_act_ff) begin
         nxt_fast_on = hs_en_ff;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_on_ff <= 1'b1;
         slow_on_ff <= 1'b1;
      end else begin
         fast_on_ff <= nxt_fast_on;
         slow_on_ff <= nxt_slow_on;
      end
   end
   assign hs_stable = (hs_cnt_ff == HS_MAX);
   assign ls_stable = (ls_cnt_ff == LS_MAX);
   // Enable write restarts the settle count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_cnt_ff <= '0;
      end else if (!fast_on_ff ||
                   (wr_en && paddr == pms_pkg::ADDR_FAST_OSC &&
                    pwdata[pms_pkg::HS_EN_BIT] && !hs_en_ff)) begin
         hs_cnt_ff <= '0;
      end else if (!hs_stable) begin
         hs_cnt_ff <= hs_cnt_ff + 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_cnt_ff <= '0;
      end else if (!slow_on_ff) begin
         ls_cnt_ff <= '0;
      end else if (!ls_stable) begin
         ls_cnt_ff <= ls_cnt_ff + 1'b1;
      end
   end

   // ==================================================
   // System clock selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_act_ff <= 1'b0;
      end else if (sel_ff == pms_pkg::SEL_SLOW) begin
         if (ls_stable) begin
            slow_act_ff <= 1'b1;
         end
      end else begin
         slow_act_ff <= 1'b0;
      end
   end

   // ==================================================
   // Wake detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         porta_prev_ff <= '0;
      end else begin
         porta_prev_ff <= porta_in;
      end
   end
   assign porta_fall = |(porta_prev_ff & ~porta_in & wake_en_ff);
   assign int_new = |(int_req & ~int_snap_ff);
   assign wake_any = porta_fall || int_new || cpu_req.wdt_overflow;
   // Requests already raised at halt are masked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_snap_ff <= '0;
      end else if (state_ff == pms_pkg::ST_RUN && cpu_req.halt) begin
         int_snap_ff <= int_req;
      end else if (halted) begin
         int_snap_ff <= int_snap_ff & int_req;
      end
   end

   // ==================================================
   // Mode sequencer
   always_comb begin
      case ({hs_idle_ff, ls_idle_ff})
         2'b00: nxt_mode = pms_pkg::MODE_SLEEP;
         2'b01: nxt_mode = pms_pkg::MODE_IDLE_SLOW;
         2'b11: nxt_mode = pms_pkg::MODE_IDLE_BOTH;
         default: nxt_mode = pms_pkg::MODE_IDLE_FAST;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= pms_pkg::ST_RUN;
         mode_ff <= pms_pkg::MODE_RUN;
         wake_wdt_ff <= 1'b0;
         wake_int_ff <= 1'b0;
      end else begin
         case (state_ff)
            pms_pkg::ST_RUN: begin
               if (cpu_req.halt) begin
                  state_ff <= pms_pkg::ST_HALTED;
                  mode_ff <= nxt_mode;
               end
            end
            pms_pkg::ST_HALTED: begin
               if (wake_any) begin
                  state_ff <= pms_pkg::ST_WAKE;
                  wake_wdt_ff <= cpu_req.wdt_overflow;
                  wake_int_ff <= int_new && !porta_fall &&
                                 !cpu_req.wdt_overflow;
               end
            end
            pms_pkg::ST_WAKE: begin
               if (wake_done) begin
                  state_ff <= pms_pkg::ST_RUN;
                  mode_ff <= pms_pkg::MODE_RUN;
                  wake_wdt_ff <= 1'b0;
                  wake_int_ff <= 1'b0;
               end
            end
            default: begin
               state_ff <= pms_pkg::ST_RUN;
            end
         endcase
      end
   end

   // ==================================================
   // Status flags, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdf_ff <= 1'b0;
         to_ff <= 1'b0;
      end else begin
         if (state_ff == pms_pkg::ST_RUN && cpu_req.halt) begin
            pdf_ff <= 1'b1;
         end else if (cpu_req.clr_wdt) begin
            pdf_ff <= 1'b0;
         end
         if (halted && cpu_req.wdt_overflow) begin
            to_ff <= 1'b1;
         end else if (state_ff == pms_pkg::ST_RUN && cpu_req.halt) begin
            to_ff <= 1'b0;
         end
      end
   end

   // ==================================================
   // Core response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.stall <= (state_ff != pms_pkg::ST_RUN) ||
                         cpu_req.halt;
         rsp_ff.wdt_clear <= state_ff == pms_pkg::ST_RUN &&
                             cpu_req.halt;
         rsp_ff.wdt_run <= cpu_req.wdt_enable;
         rsp_ff.wake <= 1'b0;
         rsp_ff.int_response <= 1'b0;
         rsp_ff.pc_sp_reset <= 1'b0;
         if (wake_done) begin
            rsp_ff.stall <= 1'b0;
            rsp_ff.wake <= 1'b1;
            rsp_ff.pc_sp_reset <= wake_wdt_ff;
            rsp_ff.int_response <= wake_int_ff &&
               |(int_req & int_en_ff) && !cpu_req.stack_full;
         end
      end
   end

   // ==================================================
   // Outputs
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign cpu_rsp = rsp_ff;
   assign fast_osc_on = fast_on_ff;
   assign slow_osc_on = slow_on_ff;
   assign sysclk_is_slow = slow_act_ff;
   assign sysclk_div_sel = sel_ff;
   assign mode = mode_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysclk_run <= 1'b1;
      end else begin
         sysclk_run <= wake_done ||
                       (!(halted || state_ff == pms_pkg::ST_WAKE) &&
                        !(state_ff == pms_pkg::ST_RUN && cpu_req.halt));
      end
   end

endmodule

/* File: test/pms_chk.sv */
// Port-level assertion checker for the mode and clock sequencer
module pms_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // CPU core
   input wire pms_pkg::pms_cpu_req_t cpu_req,
   input wire pms_pkg::pms_cpu_rsp_t cpu_rsp,
   // Clock controls
   input wire logic fast_osc_on,
   input wire logic slow_osc_on,
   input wire logic sysclk_run,
   input wire pms_pkg::pms_mode_t mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==================================================
   // Halt entry steps
   sequence s_halt;
      cpu_req.halt && mode == pms_pkg::MODE_RUN;
   endsequence
   sequence s_halted;
      cpu_rsp.stall && !sysclk_run && cpu_rsp.wdt_clear;
   endsequence
   chk_halt_stall: assert property (s_halt |=> s_halted)
      else $error("halt not followed by stall");
   chk_halt_mode: assert property (s_halt |=> mode != pms_pkg::MODE_RUN)
      else $error("halt left mode at run");
   chk_sleep_clk: assert property ($rose(mode == pms_pkg::MODE_SLEEP)
      |=> !fast_osc_on) else $error("fast clock kept in sleep");
   chk_idle_slow: assert property ($rose(mode == pms_pkg::MODE_IDLE_SLOW)
      |=> !fast_osc_on && slow_osc_on) else $error("slow idle clocks");
   chk_idle_both: assert property ($rose(mode == pms_pkg::MODE_IDLE_BOTH)
      |=> fast_osc_on && slow_osc_on) else $error("both idle clocks");
   chk_idle_fast: assert property ($rose(mode == pms_pkg::MODE_IDLE_FAST)
      |=> fast_osc_on) else $error("fast idle clock off");
   chk_wake_run: assert property ($fell(cpu_rsp.stall)
      |-> cpu_rsp.wake && sysclk_run && mode == pms_pkg::MODE_RUN)
      else $error("stall dropped without wake");
   chk_wake_stalled: assert property (cpu_rsp.wake |-> $past(cpu_rsp.stall))
      else $error("wake while not stalled");
   chk_pcsp_wake: assert property (cpu_rsp.pc_sp_reset |-> cpu_rsp.wake)
      else $error("counter reset without wake");
   chk_int_resp: assert property (cpu_rsp.int_response
      |-> cpu_rsp.wake && !cpu_req.stack_full) else $error("bad interrupt response");
   chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
endmodule

bind pms_sequencer pms_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
   .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
   .sysclk_run(sysclk_run), .mode(mode));

/* File: test/pms_cpu_model.sv */
// CPU core stand-in: one-cycle halt, fetch held until wake
module pms_cpu_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench commands
   input wire logic halt_go,
   input wire logic clr_go,
   input wire logic wdt_en,
   input wire logic ovf,
   input wire logic stk_full,
   // Sequencer side
   input wire pms_pkg::pms_cpu_rsp_t cpu_rsp,
   output pms_pkg::pms_cpu_req_t cpu_req,
   output logic fetch_hold
);
   logic halt_ff;
   logic clr_ff;
   logic hold_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_ff <= 1'b0;
         clr_ff <= 1'b0;
      end else begin
         halt_ff <= halt_go && !halt_ff && !hold_ff;
         clr_ff <= clr_go && !clr_ff;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_ff <= 1'b0;
      end else if (cpu_rsp.wake) begin
         hold_ff <= 1'b0;
      end else if (halt_ff) begin
         hold_ff <= 1'b1;
      end
   end
   assign fetch_hold = hold_ff;
   assign cpu_req = '{halt_ff, clr_ff, wdt_en, ovf, stk_full};
endmodule

/* File: test/test_pms_sequencer.sv */
// Self-checking bench for the mode and clock sequencer
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_pms_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] porta_in = 8'hff;
   logic [3:0] int_req = 4'h0;
   logic halt_go = 1'b0;
   logic clr_go = 1'b0;
   logic wdt_en = 1'b0;
   logic ovf = 1'b0;
   logic stk_full = 1'b0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, fetch_hold, wk_int, wk_pcsp;
   logic fast_osc_on, slow_osc_on, sysclk_is_slow, sysclk_run;
   logic [2:0] sysclk_div_sel;
   pms_pkg::pms_mode_t mode;
   pms_pkg::pms_cpu_req_t cpu_req;
   pms_pkg::pms_cpu_rsp_t cpu_rsp;
   int mismatches = 0;
   int cmp_count = 0;
   localparam logic [1:0] IB [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
   localparam logic [2:0] MD [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
   localparam logic [1:0] WX [5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
   always #50 pclk = ~pclk;
   pms_sequencer #(.HS_CYC(8), .LS_CYC(8)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
      .porta_in(porta_in), .int_req(int_req), .fast_osc_on(fast_osc_on),
      .slow_osc_on(slow_osc_on), .sysclk_is_slow(sysclk_is_slow),
      .sysclk_div_sel(sysclk_div_sel), .sysclk_run(sysclk_run), .mode(mode));
   pms_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .halt_go(halt_go),
      .clr_go(clr_go), .wdt_en(wdt_en), .ovf(ovf), .stk_full(stk_full),
      .cpu_rsp(cpu_rsp), .cpu_req(cpu_req), .fetch_hold(fetch_hold));
   // ==================================================
   // Bus and sequencing tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      `CHK(pready, 1'b1)
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask
   task automatic halt();
      @(posedge pclk);
      halt_go <= 1'b1;
      @(posedge pclk);
      halt_go <= 1'b0;
      cyc(3);
   endtask
   task automatic wait_wake();
      int n;
      n = 0;
      do @(posedge pclk); while (cpu_rsp.wake !== 1'b1 && ++n < 100);
      wk_int = cpu_rsp.int_response;
      wk_pcsp = cpu_rsp.pc_sp_reset;
      `CHK(n < 100, 1'b1)
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      test_done();
   end
   // ==================================================
   // Main sequence
   initial begin
      cyc(12);
      presetn <= 1'b1;
      rd_chk(pms_pkg::ADDR_SYSCLK_CTRL, 32'h0);
      apb(1'b0, pms_pkg::ADDR_FAST_OSC, 32'h0);
      `CHK(rdat[0], 1'b1)
      apb(1'b1, pms_pkg::ADDR_FAST_OSC, 32'h0);
      apb(1'b1, pms_pkg::ADDR_FAST_OSC, 32'hfd);
      rd_chk(pms_pkg::ADDR_FAST_OSC, 32'h1);
      cyc(12);
      rd_chk(pms_pkg::ADDR_FAST_OSC, 32'h3);
      apb(1'b0, 8'h14, 32'h0);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      apb(1'b1, pms_pkg::ADDR_SYSCLK_CTRL, 32'hff);
      rd_chk(pms_pkg::ADDR_SYSCLK_CTRL, 32'he3);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, pms_pkg::ADDR_SYSCLK_CTRL, {24'h0, i[2:0], 5'h0});
         cyc(2);
         `CHK({sysclk_is_slow, sysclk_div_sel}, {1'b0, i[2:0]})
      end
      apb(1'b1, pms_pkg::ADDR_SYSCLK_CTRL, 32'he0);
      cyc(12);
      `CHK(sysclk_is_slow, 1'b1)
      apb(1'b0, pms_pkg::ADDR_STATUS, 32'h0);
      `CHK(rdat[3:2], 2'h3)
      apb(1'b1, pms_pkg::ADDR_FAST_OSC, 32'h0);
      cyc(2);
      `CHK(fast_osc_on, 1'b0)
      rd_chk(pms_pkg::ADDR_FAST_OSC, 32'h0);
      apb(1'b1, pms_pkg::ADDR_FAST_OSC, 32'h1);
      apb(1'b1, pms_pkg::ADDR_SYSCLK_CTRL, 32'h0);
      cyc(2);
      `CHK(sysclk_is_slow, 1'b0)
      rd_chk(pms_pkg::ADDR_FAST_OSC, 32'h1);
      cyc(12);
      rd_chk(pms_pkg::ADDR_FAST_OSC, 32'h3);
      apb(1'b1, pms_pkg::ADDR_WAKE_EN, 32'h1);
      apb(1'b1, pms_pkg::ADDR_INT_EN, 32'h1);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, pms_pkg::ADDR_SYSCLK_CTRL, {30'h0, IB[i]});
         wdt_en <= (i != 0);
         stk_full <= (i == 3);
         int_req <= (i == 0) ? 4'h4 : 4'h0;
         halt();
         `CHK(mode, MD[i])
         `CHK(cpu_rsp.wdt_run, wdt_en)
         if (IB[i] == 2'h0) `CHK(slow_osc_on, wdt_en)
         apb(1'b0, pms_pkg::ADDR_STATUS, 32'h0);
         `CHK(rdat[1:0], 2'h1)
         rd_chk(pms_pkg::ADDR_SYSCLK_CTRL, {30'h0, IB[i]});
         case (i)
            0: begin
               porta_in <= 8'hfd;
               cyc(20);
               `CHK(fetch_hold, 1'b1)
               porta_in <= 8'hfc;
            end
            1, 3: int_req <= 4'h1;
            2: ovf <= 1'b1;
            default: int_req <= 4'h2;
         endcase
         wait_wake();
         porta_in <= 8'hff;
         int_req <= 4'h0;
         ovf <= 1'b0;
         `CHK({wk_int, wk_pcsp}, WX[i])
         cyc(2);
         if (i == 2) begin
            apb(1'b0, pms_pkg::ADDR_STATUS, 32'h0);
            `CHK(rdat[1:0], 2'h3)
         end
      end
      @(posedge pclk);
      clr_go <= 1'b1;
      @(posedge pclk);
      clr_go <= 1'b0;
      cyc(2);
      apb(1'b0, pms_pkg::ADDR_STATUS, 32'h0);
      `CHK(rdat[0], 1'b0)
      test_done();
   end
endmodule
